// ---- include/cpag_defs.svh ----
`ifndef CPAG_DEFS_SVH
`define CPAG_DEFS_SVH

// ====================================================================
// register indices, byte address is four times the index
`define CPAG_IDX_CONFIG 8'h00
`define CPAG_IDX_BASE_LO 8'h19
`define CPAG_IDX_BASE_HI 8'h1A
`define CPAG_IDX_CURSOR_LO 8'h1C
`define CPAG_IDX_CURSOR_HI 8'h1D
`define CPAG_IDX_COMMAND 8'h20
`define CPAG_IDX_PARAM 8'h21
`define CPAG_IDX_STATUS 8'h22

// ====================================================================
// field positions
`define CPAG_BIT_SOURCE 0
`define CPAG_BIT_HEIGHT 2
`define CPAG_BIT_ST_WRITE 0
`define CPAG_BIT_ST_DIR 1
`define CPAG_BIT_ST_WAIT 3

// ====================================================================
// command codes
`define CPAG_CMD_SET_BASE 8'h5C
`define CPAG_CMD_CURSOR_LOAD 8'h46
`define CPAG_CMD_MEM_WRITE 8'h42
`define CPAG_CMD_STEP_FIRST 8'h4C
`define CPAG_CMD_STEP_LAST 8'h4F

// ====================================================================
// reset values
`define CPAG_RST_SOURCE 1'h0
`define CPAG_RST_HEIGHT 1'h0
`define CPAG_RST_BASE 16'h0000
`define CPAG_RST_CURSOR 16'h0000
`define CPAG_RST_DIR 2'h0

// ====================================================================
// glyph geometry and code ranges
`define CPAG_GLYPH_W 5
`define CPAG_GLYPH_H 7
`define CPAG_FIXED_COUNT 160
`define CPAG_RAM_CHARS 64
`define CPAG_RAM_LO_FIRST 8'h80
`define CPAG_RAM_LO_LAST 8'h9F
`define CPAG_RAM_HI_FIRST 8'hE0
`define CPAG_FIXED_LO_FIRST 8'h20
`define CPAG_FIXED_HI_FIRST 8'hA0
`define CPAG_FIXED_HI_LAST 8'hDF

`endif

// ---- include/cpag_pkg.sv ----
package cpag_pkg;

    // ================================================================
    // command sequencer
    typedef enum logic [2:0] {
        CPAG_IDLE,
        CPAG_BASE_LO,
        CPAG_BASE_HI,
        CPAG_CSR_LO,
        CPAG_CSR_HI,
        CPAG_WRITE
    } cpag_cmd_e;

    // ================================================================
    // carriers
    typedef struct packed {
        logic req;
        logic [7:0] code;
        logic [3:0] row;
    } cpag_fetch_req_s;

    typedef struct packed {
        logic valid;
        logic from_ram;
        logic [15:0] addr;
        logic [7:0] rom_row;
    } cpag_fetch_rsp_s;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } cpag_mem_wr_s;

endpackage

// ---- logic/cpag_addr_calc.sv ----
`timescale 1ns/1ps
`include "cpag_defs.svh"

module cpag_addr_calc
    import cpag_pkg::*;
(
    input wire logic [15:0] base,
    input wire logic [7:0] code,
    input wire logic [3:0] row,
    input wire logic tall_font,
    input wire logic use_fixed,
    output logic [15:0] addr,
    output logic from_ram
);

    function automatic logic ram_code(input logic [7:0] c);
        ram_code = (c >= `CPAG_RAM_LO_FIRST && c <= `CPAG_RAM_LO_LAST)
                   || (c >= `CPAG_RAM_HI_FIRST);
    endfunction

    logic [15:0] offset;

    always_comb
    begin
        if (tall_font)
        begin
            offset = {4'h0, code, 4'h0} + {12'h000, row}; // [R9] [R10] [R5]
        end
        else
        begin
            offset = {5'h00, code, 3'h0} + {13'h0000, row[2:0]}; // [R8] [R10] [R5]
        end
        // carry out of bit 15 is dropped by the 16-bit target
        addr = base + offset; // [R7] [R19]
        // 32 + 32 codes go to pattern ram beside the fixed set
        from_ram = !use_fixed || ram_code(code); // [R11] [R12] [R3] [R6]
    end

endmodule

// ---- logic/cpag_glyph_store.sv ----
`timescale 1ns/1ps
`include "cpag_defs.svh"

module cpag_glyph_store
    import cpag_pkg::*;
(
    input wire logic [7:0] code,
    input wire logic [3:0] row,
    output logic [7:0] row_bits
);

    // stand-in bitmap; replace this function body with the real font table
    function automatic logic [`CPAG_GLYPH_W-1:0] glyph_bits(
        input logic [7:0] c,
        input logic [2:0] r
    );
        glyph_bits = c[4:0] ^ {r, r[1:0]};
    endfunction

    function automatic logic fixed_code(input logic [7:0] c);
        fixed_code = (c >= `CPAG_FIXED_LO_FIRST && c < `CPAG_RAM_LO_FIRST)
                     || (c >= `CPAG_FIXED_HI_FIRST && c <= `CPAG_FIXED_HI_LAST);
    endfunction

    always_comb
    begin
        row_bits = 8'h00;
        // 96 + 64 codes hold a 5 x 7 glyph, the rest are blank
        if (fixed_code(code) && row < 4'(`CPAG_GLYPH_H)) // [R1] [R2]
        begin
            // left-justified, blank columns and rows pad the 8 x 16 cell
            row_bits = {glyph_bits(code, row[2:0]), 3'h0}; // [R1] [R4]
        end
    end

endmodule

// ---- logic/cpag_char_pattern.sv ----
`timescale 1ns/1ps
`include "cpag_defs.svh"

// ====================================================================
// character pattern address generator
// ====================================================================

// Operation
// R1: fixed glyph store gives glyphs five pixels wide, seven tall.
// R2: fixed glyph store holds 160 predefined characters.
// R3: with fixed store in use, 64 pattern ram characters also display.
// R4: fixed glyphs are padded with blank space to fill up to 8 x 16.
// R5: pattern ram glyphs are 8 x 8 when height bit is 0, else 8 x 16.
// R6: with fixed store selected, pattern ram may sit anywhere in memory.
// R7: row address is base plus positioned code plus row index.
// R8: short fonts put code at bits 10..3 and row at bits 2..0.
// R9: tall fonts put code at bits 11..4 and row at bits 3..0.
// R10: row index width follows glyph height: 3 bits up to 8 lines.
// R11: codes 80h-9Fh and E0h-FFh use pattern ram, others fixed store.
// R12: without fixed store all codes use pattern ram; host sets base zero.
// R13: command 5Ch takes low then high byte of the sixteen-bit base.
// R14: command 4Ch makes the cursor step one address right per access.
// R15: command 46h takes low then high byte of the cursor address.
// R16: after command 42h each parameter byte is stored as the next row.
// R17: every memory access moves the cursor by the selected step.
// R18: source select bit of the config register picks the fixed store.
// R19: the address sum wraps at sixteen bits, carry discarded.
module cpag_char_pattern
    import cpag_pkg::*;
#(
    parameter logic [15:0] CURSOR_PITCH = 16'h0080
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire cpag_fetch_req_s FETCH_IN,
    output cpag_fetch_rsp_s FETCH_OUT,
    output cpag_mem_wr_s MEM_OUT
);

    // ================================================================
    // elaboration checks
    if (CURSOR_PITCH == 16'h0000)
    begin : g_pitch_check
        $error("cursor pitch must not be zero");
    end

    // ================================================================
    // state
    cpag_cmd_e state;
    cpag_cmd_e next_state;
    logic source;
    logic next_source;
    logic height;
    logic next_height;
    logic [15:0] base;
    logic [15:0] next_base;
    logic [15:0] cursor;
    logic [15:0] next_cursor;
    logic [1:0] dir;
    logic [1:0] next_dir;
    cpag_mem_wr_s mem;
    cpag_mem_wr_s next_mem;

    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pready;
    logic next_pready;
    logic pslverr;
    logic next_pslverr;

    cpag_fetch_rsp_s fetch;
    cpag_fetch_rsp_s next_fetch;

    logic setup;
    logic wr_commit;
    logic [7:0] widx;
    logic [7:0] wbyte;
    logic [15:0] calc_addr;
    logic calc_from_ram;
    logic [7:0] rom_row;

    // ================================================================
    // decoding helpers
    function automatic logic reg_known(input logic [11:0] a);
        logic ok;
        ok = 1'b0;
        if (a[11:10] == 2'h0 && a[1:0] == 2'h0)
        begin
            unique case (a[9:2])
                `CPAG_IDX_CONFIG,
                `CPAG_IDX_BASE_LO,
                `CPAG_IDX_BASE_HI,
                `CPAG_IDX_CURSOR_LO,
                `CPAG_IDX_CURSOR_HI,
                `CPAG_IDX_COMMAND,
                `CPAG_IDX_PARAM,
                `CPAG_IDX_STATUS:
                    ok = 1'b1;
                default:
                    ok = 1'b0;
            endcase
        end
        reg_known = ok;
    endfunction

    function automatic logic [15:0] step_cursor(
        input logic [15:0] c,
        input logic [1:0] d
    );
        logic [15:0] r;
        r = c;
        unique case (d)
            2'h0: r = c + 16'h0001;
            2'h1: r = c - 16'h0001;
            2'h2: r = c - CURSOR_PITCH;
            2'h3: r = c + CURSOR_PITCH;
        endcase
        step_cursor = r;
    endfunction

    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `CPAG_IDX_CONFIG:
            begin
                v[`CPAG_BIT_SOURCE] = source;
                v[`CPAG_BIT_HEIGHT] = height;
            end
            `CPAG_IDX_BASE_LO: v = base[7:0];
            `CPAG_IDX_BASE_HI: v = base[15:8];
            `CPAG_IDX_CURSOR_LO: v = cursor[7:0];
            `CPAG_IDX_CURSOR_HI: v = cursor[15:8];
            `CPAG_IDX_STATUS:
            begin
                v[`CPAG_BIT_ST_WRITE] = (state == CPAG_WRITE);
                v[`CPAG_BIT_ST_DIR +: 2] = dir;
                v[`CPAG_BIT_ST_WAIT] = (state != CPAG_IDLE) && (state != CPAG_WRITE);
            end
            default: v = 8'h00;
        endcase
        read_byte = v;
    endfunction

    // ================================================================
    // apb slave
    // answer is prepared in the setup cycle so that every bus output
    // comes from a flip-flop and the access phase still needs no wait
    assign setup = PSEL && !PENABLE;
    assign wr_commit = PSEL && PENABLE && pready && PWRITE && !pslverr;
    assign widx = PADDR[9:2];
    assign wbyte = PWDATA[7:0];

    always_comb
    begin
        next_pready = setup;
        next_pslverr = setup && !reg_known(PADDR);
        next_prdata = 32'h0000_0000;
        if (setup && !PWRITE && reg_known(PADDR))
        begin
            next_prdata = {24'h00_0000, read_byte(widx)};
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign PRDATA = prdata;

    // ================================================================
    // configuration, command sequencer and memory writes
    always_comb
    begin
        next_state = state;
        next_source = source;
        next_height = height;
        next_base = base;
        next_cursor = cursor;
        next_dir = dir;
        next_mem = mem;
        next_mem.wr = 1'b0;
        if (wr_commit)
        begin
            unique case (widx)
                `CPAG_IDX_CONFIG:
                begin
                    next_source = wbyte[`CPAG_BIT_SOURCE]; // [R18]
                    next_height = wbyte[`CPAG_BIT_HEIGHT]; // [R5]
                end
                `CPAG_IDX_BASE_LO: next_base[7:0] = wbyte;
                `CPAG_IDX_BASE_HI: next_base[15:8] = wbyte;
                `CPAG_IDX_CURSOR_LO: next_cursor[7:0] = wbyte;
                `CPAG_IDX_CURSOR_HI: next_cursor[15:8] = wbyte;
                `CPAG_IDX_COMMAND:
                begin
                    // a new command always ends the one in progress
                    next_state = CPAG_IDLE;
                    if (wbyte == `CPAG_CMD_SET_BASE)
                    begin
                        next_state = CPAG_BASE_LO; // [R13]
                    end
                    else if (wbyte == `CPAG_CMD_CURSOR_LOAD)
                    begin
                        next_state = CPAG_CSR_LO; // [R15]
                    end
                    else if (wbyte == `CPAG_CMD_MEM_WRITE)
                    begin
                        next_state = CPAG_WRITE; // [R16]
                    end
                    else if (wbyte >= `CPAG_CMD_STEP_FIRST && wbyte <= `CPAG_CMD_STEP_LAST)
                    begin
                        // 4Ch gives step +1, the others left, up, down
                        next_dir = wbyte[1:0]; // [R14]
                    end
                end
                `CPAG_IDX_PARAM:
                begin
                    unique case (state)
                        CPAG_IDLE:
                        begin
                            next_state = CPAG_IDLE;
                        end
                        CPAG_BASE_LO:
                        begin
                            next_base[7:0] = wbyte; // [R13]
                            next_state = CPAG_BASE_HI;
                        end
                        CPAG_BASE_HI:
                        begin
                            next_base[15:8] = wbyte; // [R13]
                            next_state = CPAG_IDLE;
                        end
                        CPAG_CSR_LO:
                        begin
                            next_cursor[7:0] = wbyte; // [R15]
                            next_state = CPAG_CSR_HI;
                        end
                        CPAG_CSR_HI:
                        begin
                            next_cursor[15:8] = wbyte; // [R15]
                            next_state = CPAG_IDLE;
                        end
                        CPAG_WRITE:
                        begin
                            // one byte is one glyph row, rows ascend with the cursor
                            next_mem.wr = 1'b1; // [R16]
                            next_mem.addr = cursor; // [R16]
                            next_mem.data = wbyte; // [R16]
                            next_cursor = step_cursor(cursor, dir); // [R17] [R14]
                        end
                    endcase
                end
                default:
                begin
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state <= CPAG_IDLE;
            source <= `CPAG_RST_SOURCE;
            height <= `CPAG_RST_HEIGHT;
            base <= `CPAG_RST_BASE;
            cursor <= `CPAG_RST_CURSOR;
            dir <= `CPAG_RST_DIR;
            mem <= '0;
        end
        else
        begin
            state <= next_state;
            source <= next_source;
            height <= next_height;
            base <= next_base;
            cursor <= next_cursor;
            dir <= next_dir;
            mem <= next_mem;
        end
    end

    assign MEM_OUT = mem;

    // ================================================================
    // glyph fetch for the display scan
    // the base is used as written; software keeps it zero when the
    // fixed store is off, the logic does not force it
    cpag_addr_calc u_addr_calc
    (
        .base(base),
        .code(FETCH_IN.code),
        .row(FETCH_IN.row),
        .tall_font(height),
        .use_fixed(!source),
        .addr(calc_addr),
        .from_ram(calc_from_ram)
    );

    cpag_glyph_store u_glyph_store
    (
        .code(FETCH_IN.code),
        .row(FETCH_IN.row),
        .row_bits(rom_row)
    );

    always_comb
    begin
        next_fetch = fetch;
        next_fetch.valid = FETCH_IN.req;
        if (FETCH_IN.req)
        begin
            next_fetch.from_ram = calc_from_ram; // [R11] [R12] [R18]
            next_fetch.addr = calc_addr; // [R7]
            next_fetch.rom_row = calc_from_ram ? 8'h00 : rom_row; // [R4]
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            fetch <= '0;
        end
        else
        begin
            fetch <= next_fetch;
        end
    end

    assign FETCH_OUT = fetch;

endmodule

// ---- test/cpag_char_pattern_checker.sv ----
`timescale 1ns/1ps

// ====================================================================
// port-level checker for the pattern address generator
module cpag_char_pattern_checker
    import cpag_pkg::*;
#(
    parameter logic [15:0] CURSOR_PITCH = 16'h0080
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire cpag_fetch_req_s FETCH_IN,
    input wire cpag_fetch_rsp_s FETCH_OUT,
    input wire cpag_mem_wr_s MEM_OUT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_param_commit;
        PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == 12'h084;
    endsequence

    sequence s_ram_code;
        FETCH_IN.req && (FETCH_IN.code inside {[8'h80:8'h9F], [8'hE0:8'hFF]});
    endsequence

    a_ready_after_setup: assert property (s_setup |=> PREADY)
        else $error("no ready after setup cycle");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_reads_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
        else $error("refused access without ready or with data");
    a_write_from_param: assert property (MEM_OUT.wr |-> $past(PWDATA[7:0]) == MEM_OUT.data
        && $past(PSEL && PENABLE && PREADY && PWRITE) && $past(PADDR) == 12'h084)
        else $error("memory write not caused by a parameter byte");
    a_param_wr_once: assert property (s_param_commit ##1 MEM_OUT.wr |=> !MEM_OUT.wr)
        else $error("memory write strobe too long");
    a_fetch_pulse: assert property (1'b1 |=> FETCH_OUT.valid == $past(FETCH_IN.req))
        else $error("fetch answer not one cycle after request");
    a_ram_codes: assert property (s_ram_code |=> FETCH_OUT.from_ram)
        else $error("pattern ram code served from fixed store");
    a_ram_row_blank: assert property (FETCH_OUT.valid && FETCH_OUT.from_ram
        |-> FETCH_OUT.rom_row == 8'h00)
        else $error("fixed row shown for pattern ram code");
    a_glyph_width: assert property (FETCH_OUT.valid |-> FETCH_OUT.rom_row[2:0] == 3'h0)
        else $error("fixed glyph wider than five pixels");
    a_pad_rows: assert property (FETCH_IN.req && FETCH_IN.row >= 4'h7
        |=> FETCH_OUT.rom_row == 8'h00)
        else $error("fixed glyph row not blank past seven lines");
    a_fields_hold: assert property (!FETCH_IN.req |=> $stable(FETCH_OUT.addr)
        && $stable(FETCH_OUT.from_ram))
        else $error("fetch fields moved without request");
endmodule

bind cpag_char_pattern cpag_char_pattern_checker #(.CURSOR_PITCH(CURSOR_PITCH)) u_checker (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FETCH_IN(FETCH_IN), .FETCH_OUT(FETCH_OUT), .MEM_OUT(MEM_OUT));

// ---- test/cpag_disp_mem.sv ----
`timescale 1ns/1ps

// ====================================================================
// display memory standing behind the memory write port
module cpag_disp_mem
    import cpag_pkg::*;
(
    input wire logic MCLK,
    input wire cpag_mem_wr_s mem_in
);
    logic [7:0] mem [logic [15:0]];

    always @(posedge MCLK)
    begin
        if (mem_in.wr === 1'b1)
        begin
            mem[mem_in.addr] = mem_in.data;
        end
    end

    // unwritten places answer with the inverted low address byte, zero only where that byte is FFh
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : ~a[7:0];
    endfunction
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "cpag_defs.svh"

module testbench
    import cpag_pkg::*;
;
    localparam logic [15:0] PITCH = 16'h0080;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cpag_fetch_req_s fetch_in = '0;
    cpag_fetch_rsp_s fetch_out;
    cpag_mem_wr_s mem_out;
    int num_errors = 0;
    int n_compared = 0;
    logic src = 1'b0;
    logic tall = 1'b0;
    logic [15:0] base;
    logic [15:0] cur;
    logic [31:0] rd;
    logic err;
    logic [7:0] glyph [8] = '{8'h70, 8'h88, 8'h88, 8'h88, 8'hF8, 8'h88, 8'h88, 8'h00};
    logic [15:0] step [4] = '{16'h0001, 16'hFFFF, 16'h0000 - PITCH, PITCH};
    logic [7:0] codes [8] = '{8'h7F, 8'h80, 8'h9F, 8'hA0, 8'hDF, 8'hE0, 8'hFF, 8'h20};

    cpag_char_pattern #(.CURSOR_PITCH(PITCH)) u_cpag_char_pattern (
        .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FETCH_IN(fetch_in), .FETCH_OUT(fetch_out), .MEM_OUT(mem_out));
    cpag_disp_mem u_cpag_disp_mem (.MCLK(mclk), .mem_in(mem_out));

    always #2 mclk = ~mclk;

    // ================================================================
    // reporting
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // ================================================================
    // bus access: hold the request until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        // ready, read data and error are taken at the rising edge itself
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, {24'h00_0000, exp});
    endtask

    task automatic wr16(input logic [7:0] cmd, input logic [15:0] v);
        wr(`CPAG_IDX_COMMAND, cmd);
        wr(`CPAG_IDX_PARAM, v[7:0]);
        wr(`CPAG_IDX_PARAM, v[15:8]);
    endtask

    task automatic cur_chk(input logic [15:0] exp);
        rdchk(`CPAG_IDX_CURSOR_LO, exp[7:0]);
        rdchk(`CPAG_IDX_CURSOR_HI, exp[15:8]);
    endtask

    // ================================================================
    // glyph fetch with expectation from config, base, code and row
    task automatic fetch(input logic [7:0] c, input logic [3:0] r);
        logic ram;
        logic [15:0] a;
        logic [7:0] g;
        ram = src | (c >= 8'h80 && c <= 8'h9F) | (c >= 8'hE0);
        if (tall)
            a = base + {4'h0, c, 4'h0} + {12'h000, r};
        else
            a = base + {5'h00, c, 3'h0} + {13'h0000, r[2:0]};
        g = 8'h00;
        if (!ram && r < 4'h7 && ((c >= 8'h20 && c <= 8'h7F) || (c >= 8'hA0 && c <= 8'hDF)))
            g = {c[4:0] ^ {r[2:0], r[1:0]}, 3'h0};
        @(posedge mclk);
        fetch_in <= '{req: 1'b1, code: c, row: r};
        @(posedge mclk);
        fetch_in.req <= 1'b0;
        @(negedge mclk);
        check(32'(fetch_out.valid), 32'h0000_0001);
        check(32'(fetch_out.from_ram), 32'(ram));
        check(32'(fetch_out.addr), 32'(a));
        check(32'(fetch_out.rom_row), 32'(g));
    endtask

    // ================================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rdchk(`CPAG_IDX_CONFIG, 8'h00);
        rdchk(`CPAG_IDX_BASE_LO, 8'h00);
        cur_chk(16'h0000);
        apb(1'b0, 8'h30, 8'h00);
        check({rd[30:0], err}, 32'h0000_0001);
        base = 16'h4000;
        wr16(`CPAG_CMD_SET_BASE, base);
        rdchk(`CPAG_IDX_BASE_LO, 8'h00);
        rdchk(`CPAG_IDX_BASE_HI, 8'h40);
        wr(`CPAG_IDX_COMMAND, `CPAG_CMD_STEP_FIRST);
        cur = 16'h4800;
        wr16(`CPAG_CMD_CURSOR_LOAD, cur);
        cur_chk(cur);
        wr(`CPAG_IDX_COMMAND, `CPAG_CMD_MEM_WRITE);
        rdchk(`CPAG_IDX_STATUS, 8'h01);
        for (int i = 0; i < 16; i++)
            wr(`CPAG_IDX_PARAM, i < 8 ? glyph[i] : 8'h00);
        cur = cur + 16'h0010;
        cur_chk(cur);
        for (int i = 0; i < 16; i++)
            check(32'(u_cpag_disp_mem.peek(16'h4800 + 16'(i))),
                  32'(i < 8 ? glyph[i] : 8'h00));
        for (int i = 0; i < 4; i++)
        begin
            wr(`CPAG_IDX_COMMAND, `CPAG_CMD_STEP_FIRST + 8'(i));
            rdchk(`CPAG_IDX_STATUS, {5'h00, 2'(i), 1'b0});
            wr(`CPAG_IDX_COMMAND, `CPAG_CMD_MEM_WRITE);
            wr(`CPAG_IDX_PARAM, 8'hA0 + 8'(i));
            cur_chk(cur + step[i]);
            check(32'(u_cpag_disp_mem.peek(cur)), 32'(8'hA0 + 8'(i)));
            cur = cur + step[i];
        end
        for (int i = 0; i < 8; i++)
            fetch(codes[i], 4'h2);
        fetch(8'h41, 4'h7);
        fetch(8'h41, 4'h0);
        wr(`CPAG_IDX_CONFIG, 8'h04);
        tall = 1'b1;
        fetch(8'h80, 4'hF);
        base = 16'hFF00;
        wr(`CPAG_IDX_COMMAND, `CPAG_CMD_SET_BASE);
        // waiting for a parameter, step direction still the last one set
        rdchk(`CPAG_IDX_STATUS, 8'h0E);
        wr(`CPAG_IDX_PARAM, base[7:0]);
        wr(`CPAG_IDX_PARAM, base[15:8]);
        fetch(8'hE0, 4'h3);
        base = 16'h0000;
        wr16(`CPAG_CMD_SET_BASE, base);
        wr(`CPAG_IDX_CONFIG, 8'h01);
        src = 1'b1;
        tall = 1'b0;
        fetch(8'h41, 4'h2);
        // second reset in mid-run must bring back the reset values
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        cur_chk(16'h0000);
        rdchk(`CPAG_IDX_CONFIG, 8'h00);
        wr(`CPAG_IDX_CURSOR_LO, 8'h34);
        wr(`CPAG_IDX_CURSOR_HI, 8'h12);
        cur_chk(16'h1234);
        complete_run();
    end
endmodule
